// >>> src/user_port_defines.svh
`ifndef USER_PORT_DEFINES_SVH
`define USER_PORT_DEFINES_SVH

`define AUX_DATA_ADDR 16'hDD00
`define USER_DATA_ADDR 16'hDD01
`define AUX_DIR_ADDR 16'hDD02
`define USER_DIR_ADDR 16'hDD03
`define FLAG_STATUS_ADDR 16'hDD04
`define FLAG_ENABLE_ADDR 16'hDD05

`define FLAG_BIT 0
`define LEVEL_BIT 1
`define IRQ_BIT 7
`define ENABLE_BIT 0
`define AUX_STROBE_BIT 2

`define PORT_DATA_RESET 8'h00
`define PORT_DIR_RESET 8'h00
`define READ_IDLE_VALUE 8'h00

`endif

// >>> src/user_port_pkg.sv
package user_port_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
	} lane_state_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_AUX_DATA,
		SEL_USER_DATA,
		SEL_AUX_DIR,
		SEL_USER_DIR,
		SEL_FLAG_STATUS,
		SEL_FLAG_ENABLE
	} reg_sel_t;

	typedef struct packed {
		logic flag;
		logic flagEnable;
		logic lastEdge;
		logic coldStart;
		logic [7:0] readData;
	} ctrl_state_t;

endpackage : user_port_pkg

// >>> src/port_lane.sv
`timescale 1ns/1ns
`include "user_port_defines.svh"
module port_lane
	import user_port_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic dataSel,
	input wire logic dirSel,
	input wire logic [7:0] wrData,
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOeN,
	output logic [7:0] portValue,
	output logic [7:0] dirValue
);

	lane_state_t st;
	lane_state_t next_st;

	always_comb begin
		next_st = st;
		if (wrEn && dataSel) begin
			next_st.data = wrData;
		end
		if (wrEn && dirSel) begin
			next_st.dir = wrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '{data: `PORT_DATA_RESET, dir: `PORT_DIR_RESET};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign pinOut = st.data;
	assign pinOeN = ~st.dir;
	// output readback
	// outputs read the latch, not the pin, so a loaded line still reads back
	assign portValue = (st.dir & st.data) | (~st.dir & pinIn);
	assign dirValue = st.dir;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_driveOut;
		dirValue[0] |-> (!pinOeN[0] && pinOut[0] == st.data[0]);
	endproperty
	a_driveOut: assert property (p_driveOut) else $error("output line not driven");

	property p_noDriveIn;
		(dirValue == 8'h00) |-> (pinOeN == 8'hFF);
	endproperty
	a_noDriveIn: assert property (p_noDriveIn) else $error("input line driven");

	property p_dataWrite;
		(ce && wrEn && dataSel) |=> (pinOut == $past(wrData));
	endproperty
	a_dataWrite: assert property (p_dataWrite) else $error("data write lost");

	property p_dirWrite;
		(ce && wrEn && dirSel) |=> (dirValue == $past(wrData));
	endproperty
	a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");

endmodule : port_lane

// >>> src/user_port_parallel_io.sv
`timescale 1ns/1ns
`include "user_port_defines.svh"
module user_port_parallel_io
	import user_port_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] cpuAddr,
	input wire logic cpuWr,
	input wire logic cpuRd,
	input wire logic [7:0] cpuWrData,
	output logic [7:0] cpuRdData,
	input wire logic [7:0] userPortIn,
	output logic [7:0] userPortOut,
	output logic [7:0] userPortOeN,
	input wire logic [7:0] auxPortIn,
	output logic [7:0] auxPortOut,
	output logic [7:0] auxPortOeN,
	input wire logic handshakeEdgeInput,
	output logic irqN,
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOeN,
	output logic coldStartReq
);

	ctrl_state_t st;
	ctrl_state_t next_st;
	reg_sel_t sel;
	logic [7:0] userValue;
	logic [7:0] userDir;
	logic [7:0] auxValue;
	logic [7:0] auxDir;
	logic fallEdge;
	logic flagClear;

	always_comb begin
		case (cpuAddr)
			`AUX_DATA_ADDR: begin
				sel = SEL_AUX_DATA;
			end
			`USER_DATA_ADDR: begin
				sel = SEL_USER_DATA;
			end
			`AUX_DIR_ADDR: begin
				sel = SEL_AUX_DIR;
			end
			`USER_DIR_ADDR: begin
				sel = SEL_USER_DIR;
			end
			`FLAG_STATUS_ADDR: begin
				sel = SEL_FLAG_STATUS;
			end
			`FLAG_ENABLE_ADDR: begin
				sel = SEL_FLAG_ENABLE;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
	end

	port_lane userLane (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.wrEn(cpuWr),
		.dataSel(sel == SEL_USER_DATA),
		.dirSel(sel == SEL_USER_DIR),
		.wrData(cpuWrData),
		.pinIn(userPortIn),
		.pinOut(userPortOut),
		.pinOeN(userPortOeN),
		.portValue(userValue),
		.dirValue(userDir)
	);

	port_lane auxLane (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.wrEn(cpuWr),
		.dataSel(sel == SEL_AUX_DATA),
		.dirSel(sel == SEL_AUX_DIR),
		.wrData(cpuWrData),
		.pinIn(auxPortIn),
		.pinOut(auxPortOut),
		.pinOeN(auxPortOeN),
		.portValue(auxValue),
		.dirValue(auxDir)
	);

	assign fallEdge = st.lastEdge && !handshakeEdgeInput;
	// write one to bit zero of the status register clears the flag
	assign flagClear = cpuWr && (sel == SEL_FLAG_STATUS) && cpuWrData[`FLAG_BIT];

	always_comb begin
		next_st = st;
		next_st.lastEdge = handshakeEdgeInput;
		// set wins over clear
		// an edge in the clearing cycle must not vanish
		if (fallEdge) begin
			next_st.flag = 1'b1;
		end else if (flagClear) begin
			next_st.flag = 1'b0;
		end
		if (cpuWr && (sel == SEL_FLAG_ENABLE)) begin
			next_st.flagEnable = cpuWrData[`ENABLE_BIT];
		end
		next_st.coldStart = !resetPinIn;
		next_st.readData = `READ_IDLE_VALUE;
		if (cpuRd) begin
			case (sel)
				SEL_AUX_DATA: begin
					next_st.readData = auxValue;
				end
				SEL_USER_DATA: begin
					next_st.readData = userValue;
				end
				SEL_AUX_DIR: begin
					next_st.readData = auxDir;
				end
				SEL_USER_DIR: begin
					next_st.readData = userDir;
				end
				SEL_FLAG_STATUS: begin
					next_st.readData[`FLAG_BIT] = st.flag;
					next_st.readData[`LEVEL_BIT] = handshakeEdgeInput;
					next_st.readData[`IRQ_BIT] = st.flag && st.flagEnable;
				end
				SEL_FLAG_ENABLE: begin
					next_st.readData[`ENABLE_BIT] = st.flagEnable;
				end
				default: begin
					next_st.readData = `READ_IDLE_VALUE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '{flag: 1'b0, flagEnable: 1'b0, lastEdge: 1'b1, coldStart: 1'b0,
				readData: `READ_IDLE_VALUE};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign cpuRdData = st.readData;
	assign irqN = !(st.flag && st.flagEnable);
	// reset driven outward
	// pin is open drain: only ever pulled low, during system reset
	assign resetPinOut = 1'b0;
	assign resetPinOeN = !rst;
	assign coldStartReq = st.coldStart;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_fall;
		ce && st.lastEdge && !handshakeEdgeInput;
	endsequence

	sequence s_statusRead;
		ce && cpuRd && (cpuAddr == `FLAG_STATUS_ADDR);
	endsequence

	sequence s_flagClear;
		ce && flagClear && !fallEdge;
	endsequence

	sequence s_enableWrite;
		ce && cpuWr && (sel == SEL_FLAG_ENABLE);
	endsequence

	property p_fallSets;
		s_fall |=> st.flag;
	endproperty
	a_fallSets: assert property (p_fallSets) else $error("falling edge missed");

	property p_setBeatsClear;
		(s_fall and (ce && flagClear)) |=> st.flag;
	endproperty
	a_setBeatsClear: assert property (p_setBeatsClear) else $error("edge lost to clear");

	property p_irqRaised;
		(ce && fallEdge && st.flagEnable && !(cpuWr && sel == SEL_FLAG_ENABLE)) |=> !irqN;
	endproperty
	a_irqRaised: assert property (p_irqRaised) else $error("enabled flag gave no request");

	property p_irqMasked;
		!st.flagEnable |-> irqN;
	endproperty
	a_irqMasked: assert property (p_irqMasked) else $error("masked flag raised request");

	property p_pollFlag;
		(s_statusRead ##0 st.flag) |=> cpuRdData[`FLAG_BIT];
	endproperty
	a_pollFlag: assert property (p_pollFlag) else $error("flag not pollable");

	property p_readBack;
		(ce && cpuRd && sel == SEL_USER_DATA && userDir[0]) |=> (cpuRdData[0] == userPortOut[0]);
	endproperty
	a_readBack: assert property (p_readBack) else $error("output readback wrong");

	property p_dirCleared;
		$past(rst) |-> (userDir == 8'h00 && auxDir == 8'h00);
	endproperty
	a_dirCleared: assert property (p_dirCleared) else $error("direction not cleared");

	property p_coldStart;
		(ce && !resetPinIn) |=> coldStartReq;
	endproperty
	a_coldStart: assert property (p_coldStart) else $error("cold start not requested");

	property p_strobeBit;
		(ce && cpuWr && sel == SEL_AUX_DATA) |=> (auxPortOut[`AUX_STROBE_BIT] == $past(cpuWrData[2]));
	endproperty
	a_strobeBit: assert property (p_strobeBit) else $error("aux bit two not written");

	property p_flagCleared;
		s_flagClear |=> (!st.flag && irqN);
	endproperty
	a_flagCleared: assert property (p_flagCleared) else $error("flag clear lost");

	property p_flagHolds;
		(ce && st.flag && !flagClear) |=> st.flag;
	endproperty
	a_flagHolds: assert property (p_flagHolds) else $error("flag dropped without clear");

	property p_noSpuriousFlag;
		(ce && !st.flag && !fallEdge) |=> !st.flag;
	endproperty
	a_noSpuriousFlag: assert property (p_noSpuriousFlag) else $error("flag set without edge");

	property p_freeze;
		!ce |=> $stable(st);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_enableWrite;
		s_enableWrite |=> (st.flagEnable == $past(cpuWrData[`ENABLE_BIT]));
	endproperty
	a_enableWrite: assert property (p_enableWrite) else $error("enable write lost");

	property p_irqSilent;
		(ce && fallEdge && !st.flagEnable && !(cpuWr && (sel == SEL_FLAG_ENABLE)))
			|=> (irqN && st.flag);
	endproperty
	a_irqSilent: assert property (p_irqSilent) else $error("masked edge not pollable");

	property p_readIdle;
		(ce && !cpuRd) |=> (cpuRdData == `READ_IDLE_VALUE);
	endproperty
	a_readIdle: assert property (p_readIdle) else $error("read data not idle");

	property p_unmappedRead;
		(ce && cpuRd && (sel == SEL_NONE)) |=> (cpuRdData == `READ_IDLE_VALUE);
	endproperty
	a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped read not idle");

	property p_userDataRead;
		(ce && cpuRd && (sel == SEL_USER_DATA)) |=> (cpuRdData == $past(userValue));
	endproperty
	a_userDataRead: assert property (p_userDataRead) else $error("user data read wrong");

	property p_userDirRead;
		(ce && cpuRd && (sel == SEL_USER_DIR)) |=> (cpuRdData == $past(userDir));
	endproperty
	a_userDirRead: assert property (p_userDirRead) else $error("user direction read wrong");

	property p_auxDirRead;
		(ce && cpuRd && (sel == SEL_AUX_DIR)) |=> (cpuRdData == $past(auxDir));
	endproperty
	a_auxDirRead: assert property (p_auxDirRead) else $error("aux direction read wrong");

	property p_unmappedWrite;
		(ce && cpuWr && (sel == SEL_NONE)) |=> ($stable(userDir) && $stable(auxDir));
	endproperty
	a_unmappedWrite: assert property (p_unmappedWrite) else $error("unmapped write landed");

	property p_statusLevel;
		s_statusRead |=> (cpuRdData[`LEVEL_BIT] == $past(handshakeEdgeInput));
	endproperty
	a_statusLevel: assert property (p_statusLevel) else $error("status level bit wrong");

	property p_statusIrqBit;
		s_statusRead |=> (cpuRdData[`IRQ_BIT] == !$past(irqN));
	endproperty
	a_statusIrqBit: assert property (p_statusIrqBit) else $error("status request bit wrong");

	property p_coldRelease;
		(ce && resetPinIn) |=> !coldStartReq;
	endproperty
	a_coldRelease: assert property (p_coldRelease) else $error("cold start without pin low");

endmodule : user_port_parallel_io

// >>> tb/port_peripheral.sv
`timescale 1ns/1ns
module port_peripheral (
	input wire logic [7:0] devOut,
	input wire logic [7:0] devOeN,
	input wire logic [7:0] farValue,
	input wire logic resetOeN,
	input wire logic resetPull,
	output logic [7:0] pinLevel,
	output logic resetLevel
);
	assign pinLevel = (devOut & ~devOeN) | (farValue & devOeN);
	assign resetLevel = !(resetPull || !resetOeN);
endmodule : port_peripheral

// >>> tb/user_port_parallel_io_tb_top.sv
`timescale 1ns/1ns
module user_port_parallel_io_tb_top;
	import user_port_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] cpuAddr = 16'h0000;
	logic cpuWr = 1'b0;
	logic cpuRd = 1'b0;
	logic [7:0] cpuWrData = 8'h00;
	logic [7:0] cpuRdData, userPortIn, userPortOut, userPortOeN;
	logic [7:0] auxPortIn, auxPortOut, auxPortOeN;
	logic handshakeEdgeInput = 1'b1;
	logic ce = 1'b1;
	logic resetPull = 1'b0;
	logic irqN, resetPinIn, resetPinOut, resetPinOeN, coldStartReq;
	int n_errors = 0;
	int compares = 0;
	always #25 sys_clk = ~sys_clk;
	user_port_parallel_io dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuWrData(cpuWrData),
		.cpuRdData(cpuRdData), .userPortIn(userPortIn), .userPortOut(userPortOut),
		.userPortOeN(userPortOeN), .auxPortIn(auxPortIn), .auxPortOut(auxPortOut),
		.auxPortOeN(auxPortOeN), .handshakeEdgeInput(handshakeEdgeInput), .irqN(irqN),
		.resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
		.coldStartReq(coldStartReq));
	port_peripheral userSide (.devOut(userPortOut), .devOeN(userPortOeN),
		.farValue(8'h5A), .resetOeN(resetPinOeN), .resetPull(resetPull),
		.pinLevel(userPortIn), .resetLevel(resetPinIn));
	port_peripheral auxSide (.devOut(auxPortOut), .devOeN(auxPortOeN),
		.farValue(8'hC3), .resetOeN(1'b1), .resetPull(1'b0),
		.pinLevel(auxPortIn), .resetLevel());
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		cpuAddr = a;
		cpuWrData = d;
		cpuWr = 1'b1;
		@(negedge sys_clk);
		cpuWr = 1'b0;
	endtask : wr
	task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		cpuAddr = a;
		cpuRd = 1'b1;
		@(negedge sys_clk);
		cpuRd = 1'b0;
		check($sformatf("reg %h", a), cpuRdData, exp);
	endtask : rd_check
	task automatic edge_pulse();
		@(negedge sys_clk);
		handshakeEdgeInput = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask : edge_pulse
	task automatic test_reset_values();
		// data reads of input lines show the far side's levels
		rd_check(16'hDD00, 8'hC3);
		rd_check(16'hDD01, 8'h5A);
		rd_check(16'hDD02, 8'h00);
		rd_check(16'hDD03, 8'h00);
		check("rstOut", {7'h00, resetPinOut}, 8'h00);
		check("userOeN", userPortOeN, 8'hFF);
		check("auxOeN", auxPortOeN, 8'hFF);
		check("rstOeN", {7'h00, resetPinOeN}, 8'h01);
	endtask : test_reset_values
	task automatic test_user_port();
		wr(16'hDD03, 8'h38);
		wr(16'hDD01, 8'hA5);
		check("userOeN", userPortOeN, 8'hC7);
		check("userOut", userPortOut & 8'h38, 8'h20);
		rd_check(16'hDD01, 8'h62);
		rd_check(16'hDD03, 8'h38);
		wr(16'hDD03, 8'h00);
		check("userOeN", userPortOeN, 8'hFF);
		rd_check(16'hDD01, 8'h5A);
	endtask : test_user_port
	task automatic test_aux_bit_two();
		wr(16'hDD02, 8'h04);
		wr(16'hDD00, 8'h04);
		check("auxOeN", auxPortOeN, 8'hFB);
		check("auxOut", auxPortOut & 8'h04, 8'h04);
		rd_check(16'hDD00, 8'hC7);
		rd_check(16'hDD02, 8'h04);
	endtask : test_aux_bit_two
	task automatic test_flag();
		edge_pulse();
		check("irqN", {7'h00, irqN}, 8'h01);
		rd_check(16'hDD04, 8'h01);
		handshakeEdgeInput = 1'b1;
		wr(16'hDD04, 8'h01);
		rd_check(16'hDD04, 8'h02);
		wr(16'hDD05, 8'h01);
		edge_pulse();
		check("irqN", {7'h00, irqN}, 8'h00);
		rd_check(16'hDD04, 8'h81);
		wr(16'hDD04, 8'h01);
		check("irqN", {7'h00, irqN}, 8'h01);
		handshakeEdgeInput = 1'b1;
	endtask : test_flag
	task automatic test_unmapped_and_pin();
		wr(16'hDD10, 8'hFF);
		rd_check(16'hDD10, 8'h00);
		rd_check(16'hDD03, 8'h00);
		@(negedge sys_clk);
		resetPull = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("coldStart", {7'h00, coldStartReq}, 8'h01);
		resetPull = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("coldStart", {7'h00, coldStartReq}, 8'h00);
	endtask : test_unmapped_and_pin
	task automatic test_set_beats_clear();
		// falling edge and clearing write land on the same clock edge
		@(negedge sys_clk);
		cpuAddr = 16'hDD04;
		cpuWrData = 8'h01;
		cpuWr = 1'b1;
		handshakeEdgeInput = 1'b0;
		@(negedge sys_clk);
		cpuWr = 1'b0;
		rd_check(16'hDD04, 8'h81);
		check("irqN", {7'h00, irqN}, 8'h00);
		handshakeEdgeInput = 1'b1;
		wr(16'hDD04, 8'h01);
		rd_check(16'hDD04, 8'h02);
	endtask : test_set_beats_clear
	task automatic test_clock_enable();
		@(negedge sys_clk);
		ce = 1'b0;
		wr(16'hDD03, 8'hFF);
		check("userOeN", userPortOeN, 8'hFF);
		edge_pulse();
		check("irqN", {7'h00, irqN}, 8'h01);
		handshakeEdgeInput = 1'b1;
		ce = 1'b1;
		rd_check(16'hDD04, 8'h02);
		rd_check(16'hDD03, 8'h00);
	endtask : test_clock_enable
	task automatic test_mid_reset();
		wr(16'hDD03, 8'hF0);
		wr(16'hDD02, 8'h0F);
		check("userOeN", userPortOeN, 8'h0F);
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("rstOeN", {7'h00, resetPinOeN}, 8'h00);
		check("rstLevel", {7'h00, resetPinIn}, 8'h00);
		check("coldStart", {7'h00, coldStartReq}, 8'h00);
		rst = 1'b0;
		check("userOeN", userPortOeN, 8'hFF);
		check("auxOeN", auxPortOeN, 8'hFF);
		rd_check(16'hDD03, 8'h00);
		rd_check(16'hDD02, 8'h00);
	endtask : test_mid_reset
	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	// run is about a hundred cycles, so this margin is generous
	initial begin
		#(3000 * 50);
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (10) @(negedge sys_clk);
		check("rstOeN", {7'h00, resetPinOeN}, 8'h00);
		rst = 1'b0;
		test_reset_values();
		test_user_port();
		test_aux_bit_two();
		test_flag();
		test_set_beats_clear();
		test_unmapped_and_pin();
		test_clock_enable();
		test_mid_reset();
		complete_run();
	end
endmodule : user_port_parallel_io_tb_top
